// ===== reset_mode_interrupt_status_bench.sv
// Bench: host end drives device end through the shared interface.
// Assumes the design files and rmis_props are compiled first.
`timescale 1ns/1ps
module reset_mode_interrupt_status_bench;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cmd_valid = 1'b0;
  rmis_pkg::rmis_op_t cmd_op = rmis_pkg::OP_WR;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic [71:0] sr_ev = 72'h0;
  logic [71:0] sr_cond = 72'h0;
  logic [15:0] info_ev = 16'h0000;
  logic [15:0] info_live = 16'h0003;
  logic [7:0] sync_rt = 8'h5a;
  logic extra = 1'b0;
  logic ready, rsp_valid, irq_act, mode_e1, f_tri, f_lo, f_hi;
  logic li_rst, chip_rst;
  logic extended_status_bus_irq, extended_status_bus_sync;
  logic li_seen = 1'b0;
  logic [7:0] rsp_data;
  int n_fail = 0;
  int checks_done = 0;

  rmis_if bus ();

  always #12.5 mclk_in = ~mclk_in;

  // Line reset is a one-cycle pulse, so latch that it was seen
  always @(posedge mclk_in)
    if (li_rst === 1'b1)
      li_seen <= 1'b1;

  rmis_host #(.LI_WAIT_CYC(20)) rmis_host_i (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .bus(bus.host), .cmd_valid_in(cmd_valid),
    .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data),
    .cmd_ready_out(ready), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data), .irq_active_out(irq_act));

  rmis_device rmis_device_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .bus(bus.dev), .sr_event_in(sr_ev), .sr_cond_in(sr_cond),
    .info_event_in(info_ev), .info_live_in(info_live),
    .sync_realtime_in(sync_rt), .extra_status_source_in(extra),
    .mode_e1_out(mode_e1), .force_tristate_out(f_tri),
    .force_low_out(f_lo), .force_high_out(f_hi),
    .line_if_reset_out(li_rst), .chip_reset_out(chip_rst),
    .extended_status_bus_irq_out(extended_status_bus_irq), .extended_status_bus_sync_out(extended_status_bus_sync));

  rmis_props rmis_props_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
    .hw_chip_reset_pin_n(bus.hw_chip_reset_pin_n), .rdata(bus.rdata),
    .data_oe(bus.data_oe), .irq_o(bus.irq_o), .irq_oe(bus.irq_oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bchk(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask

  // One host command; a lost response counts as a mismatch
  task automatic cmd(input rmis_pkg::rmis_op_t op, input logic [7:0] a,
                     input logic [7:0] d);
    int k;
    @(posedge mclk_in);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    @(posedge mclk_in);
    #1;
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 100)
    begin
      @(posedge mclk_in);
      #1;
      k++;
    end
    bchk(k < 100, 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cmd(rmis_pkg::OP_WR, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cmd(rmis_pkg::OP_RD, a, 8'h00);
    chk(rsp_data, e);
  endtask

  task automatic srd(input logic [7:0] a, input logic [7:0] s,
                     input logic [7:0] e);
    cmd(rmis_pkg::OP_SRD, a, s);
    chk(rsp_data, e);
  endtask

  // Settle covers latch, pin and the host's two-flop sync
  task automatic irq_is(input logic e);
    repeat (8) @(posedge mclk_in);
    #1;
    bchk(irq_act, e);
  endtask

  task automatic ev(input int i);
    @(posedge mclk_in);
    #1;
    sr_ev[i] = 1'b1;
    @(posedge mclk_in);
    #1;
    sr_ev[i] = 1'b0;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #(25 * 8000);
    n_fail++;
    conclude;
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge mclk_in);
    #1;
    rst_n_in = 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h17, 8'h00);
    rd(8'h40, 8'h00);
    irq_is(1'b0);
    bchk(extended_status_bus_sync, 1'b1);
    $display("test reset values done");
    wr(8'h00, 8'hf2);
    rd(8'h00, 8'h02);
    bchk(mode_e1, 1'b1);
    wr(8'h00, 8'h08);
    bchk(f_lo, 1'b1);
    irq_is(1'b1);
    wr(8'h00, 8'h0c);
    bchk(f_hi, 1'b1);
    irq_is(1'b0);
    wr(8'h00, 8'h04);
    bchk(f_tri, 1'b1);
    rd(8'h00, 8'hff);
    wr(8'h00, 8'h00);
    bchk(mode_e1, 1'b0);
    $display("test mode register done");
    ev(20);
    irq_is(1'b0);
    rd(8'h14, 8'h00);
    srd(8'h1a, 8'hff, 8'h10);
    wr(8'h17, 8'h10);
    ev(4);
    irq_is(1'b1);
    rd(8'h14, 8'h01);
    srd(8'h16, 8'hff, 8'h10);
    irq_is(1'b0);
    srd(8'h16, 8'hff, 8'h00);
    ev(4);
    ev(5);
    srd(8'h16, 8'h10, 8'h10);
    srd(8'h16, 8'h20, 8'h30);
    ev(4);
    irq_is(1'b1);
    cmd(rmis_pkg::OP_IRQ_ENTER, 8'h00, 8'h00);
    irq_is(1'b0);
    bchk(extended_status_bus_irq, 1'b1);
    cmd(rmis_pkg::OP_IRQ_EXIT, 8'h00, 8'h00);
    irq_is(1'b1);
    srd(8'h16, 8'hff, 8'h10);
    irq_is(1'b0);
    $display("test events done");
    sr_cond[8] = 1'b1;
    srd(8'h18, 8'hff, 8'h01);
    bchk(extended_status_bus_sync, 1'b0);
    srd(8'h18, 8'hff, 8'h01);
    sr_cond[8] = 1'b0;
    // Bit 0 was set again while present, so it shows once more
    srd(8'h18, 8'hff, 8'h11);
    bchk(extended_status_bus_sync, 1'b1);
    wr(8'h17, 8'h02);
    sr_cond[1] = 1'b1;
    irq_is(1'b1);
    srd(8'h16, 8'hff, 8'h02);
    irq_is(1'b0);
    sr_cond[1] = 1'b0;
    irq_is(1'b1);
    srd(8'h16, 8'hff, 8'h02);
    irq_is(1'b0);
    $display("test conditions done");
    wr(8'h27, 8'h10);
    ev(68);
    rd(8'h15, 8'h01);
    extra = 1'b1;
    rd(8'h15, 8'h03);
    srd(8'h26, 8'hff, 8'h10);
    rd(8'h15, 8'h02);
    extra = 1'b0;
    irq_is(1'b0);
    info_ev[4] = 1'b1;
    @(posedge mclk_in);
    #1;
    info_ev[4] = 1'b0;
    irq_is(1'b0);
    srd(8'h32, 8'hff, 8'h13);
    rd(8'h34, 8'h5a);
    $display("test summary and info done");
    wr(8'h31, 8'h40);
    wr(8'h00, 8'h02);
    wr(8'h00, 8'h03);
    bchk(chip_rst, 1'b1);
    repeat (6) @(posedge mclk_in);
    rd(8'h00, 8'h00);
    rd(8'h31, 8'h00);
    rd(8'h27, 8'h00);
    $display("test soft reset done");
    cmd(rmis_pkg::OP_LINE_IF_RESET_BIT, 8'h00, 8'h00);
    bchk(li_seen, 1'b1);
    rd(8'h30, 8'h40);
    wr(8'h00, 8'h02);
    cmd(rmis_pkg::OP_HWRST, 8'h00, 8'h00);
    rd(8'h00, 8'h00);
    rd(8'h30, 8'h00);
    $display("test line and pin reset done");
    conclude;
  end
endmodule // reset_mode_interrupt_status_bench

// ===== rmis_defs.svh
// Constants of the reset, mode and interrupt/status block: register
// offsets, field positions, masks and timing counts.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef RMIS_DEFS_SVH
`define RMIS_DEFS_SVH

// Register offsets on the parallel port
`define RMIS_A_MMR 8'h00
`define RMIS_A_INTERRUPT_SOURCE_SUMMARY_LOW 8'h14
`define RMIS_A_INTERRUPT_SOURCE_SUMMARY_HIGH 8'h15
`define RMIS_A_SR_BASE 8'h16
`define RMIS_A_LINE_IF_CONTROL_2 8'h30
`define RMIS_A_COMMON_CONTROL_3 8'h31
`define RMIS_A_INFO_REG_FIVE 8'h32
`define RMIS_A_INFO_REG_SIX 8'h33
`define RMIS_A_SYNC_REALTIME_INFO 8'h34

// Master mode fields
`define RMIS_MMR_SRST 0
`define RMIS_MMR_E1 1
`define RMIS_MMR_TLO 2
`define RMIS_MMR_THI 3
`define RMIS_MMR_WMASK 8'h0f

// Control bits outside the master mode register
`define RMIS_LINE_IF_CONTROL_2_LINE_IF_RESET_BIT 6
`define RMIS_LINE_IF_RESET_BIT_MASK 8'h40
`define RMIS_COMMON_CONTROL_3_IRQ_PIN_DISABLE 6
`define RMIS_IRQ_PIN_DISABLE_MASK 8'h40

// Status layout: low nibble conditions, bit 1 double-edge
`define RMIS_COND_MASK 8'h0f
`define RMIS_DBL_MASK 8'h02
`define RMIS_LOS_BIT 0
`define RMIS_LOS_CLR_BIT 4
`define RMIS_LOS_REG 1
`define RMIS_INFO_LIVE 8'h0f
`define RMIS_NSR 9
`define RMIS_NST 11

// Timing
`define RMIS_SRST_CYC 4'h4
`define RMIS_HWRST_CYC 21'h000004
`define RMIS_LI_WAIT_MS 40
`define RMIS_CLK_KHZ 40000
`define RMIS_LI_WAIT_CYC (`RMIS_LI_WAIT_MS * `RMIS_CLK_KHZ)

`endif

// ===== rmis_device.sv
// Device end: master mode, resets, latched status and interrupt logic.
// Assumes the host follows the write-then-read status protocol and that
// status sources come from logic on mclk_in.
`timescale 1ns/1ps
`include "rmis_defs.svh"
module rmis_device (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  rmis_if.dev bus,
  input wire logic [71:0] sr_event_in,
  input wire logic [71:0] sr_cond_in,
  input wire logic [15:0] info_event_in,
  input wire logic [15:0] info_live_in,
  input wire logic [7:0] sync_realtime_in,
  input wire logic extra_status_source_in,
  output logic mode_e1_out,
  output logic force_tristate_out,
  output logic force_low_out,
  output logic force_high_out,
  output logic line_if_reset_out,
  output logic chip_reset_out,
  output logic extended_status_bus_irq_out,
  output logic extended_status_bus_sync_out
);

  logic hwr_s1_r, hwr_s2_r;
  logic [7:0] mmr_r, mmr_nxt;
  logic [7:0] line_if_control_2_r, line_if_control_2_nxt;
  logic [7:0] common_control_3_r, common_control_3_nxt;
  logic [3:0] srst_cnt_r, srst_cnt_nxt;
  logic [7:0] lat_r [`RMIS_NST], lat_nxt [`RMIS_NST];
  logic [7:0] rdc_r [`RMIS_NST], rdc_nxt [`RMIS_NST];
  logic [7:0] ilat_r [`RMIS_NSR], ilat_nxt [`RMIS_NSR];
  logic [7:0] imr_r [`RMIS_NSR], imr_nxt [`RMIS_NSR];
  logic [7:0] cond_d_r [`RMIS_NSR], cond_d_nxt [`RMIS_NSR];
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic line_if_reset_bit_r, line_if_reset_bit_nxt;
  logic [7:0] interrupt_source_summary_low, interrupt_source_summary_high;
  logic irq_act, clr, tri_mode;

  // Offset of status or information register k
  function automatic logic [7:0] st_addr(input int k);
    if (k < `RMIS_NSR)
      st_addr = 8'(`RMIS_A_SR_BASE + 8'(2 * k));
    else if (k == `RMIS_NSR)
      st_addr = `RMIS_A_INFO_REG_FIVE;
    else
      st_addr = `RMIS_A_INFO_REG_SIX;
  endfunction

  // Selection byte of a write aimed at one offset, zero otherwise
  function automatic logic [7:0] wsel(input logic we,
                                      input logic [7:0] a,
                                      input logic [7:0] target,
                                      input logic [7:0] d);
    wsel = (we && a == target) ? d : 8'h00;
  endfunction

  // Reset pin comes from another chip, so it is synchronised first
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      hwr_s1_r <= 1'b1;
      hwr_s2_r <= 1'b1;
    end
    else
    begin
      hwr_s1_r <= bus.hw_chip_reset_pin_n;
      hwr_s2_r <= hwr_s1_r;
    end
  end

  // Interrupt summary and pin request
  always_comb
  begin
    interrupt_source_summary_low = 8'h00;
    for (int k = 0; k < 8; k++)
      interrupt_source_summary_low[k] = |(ilat_r[k] & imr_r[k]);
    interrupt_source_summary_high = {6'h00, extra_status_source_in,
            |(ilat_r[8] & imr_r[8])};
    irq_act = (|interrupt_source_summary_low || |interrupt_source_summary_high) && !common_control_3_r[`RMIS_COMMON_CONTROL_3_IRQ_PIN_DISABLE];
  end

  // Next state of every register and of the read path
  always_comb
  begin
    logic [7:0] sel;
    logic [7:0] cond;
    logic [7:0] evt;
    logic [7:0] rise;
    logic [7:0] fall;
    sel = 8'h00;
    cond = 8'h00;
    evt = 8'h00;
    rise = 8'h00;
    fall = 8'h00;
    mmr_nxt = mmr_r;
    line_if_control_2_nxt = line_if_control_2_r;
    common_control_3_nxt = common_control_3_r;
    srst_cnt_nxt = srst_cnt_r;
    line_if_reset_bit_nxt = 1'b0;
    clr = !hwr_s2_r || (srst_cnt_r != 4'h0);
    // Status registers with masks
    for (int k = 0; k < `RMIS_NSR; k++)
    begin
      sel = wsel(bus.wr, bus.addr, st_addr(k), bus.wdata);
      cond = sr_cond_in[k*8 +: 8] & `RMIS_COND_MASK;
      evt = sr_event_in[k*8 +: 8] & ~`RMIS_COND_MASK;
      if (k == `RMIS_LOS_REG)
        evt[`RMIS_LOS_CLR_BIT] = evt[`RMIS_LOS_CLR_BIT] |
          (cond_d_r[k][`RMIS_LOS_BIT] & ~cond[`RMIS_LOS_BIT]);
      rise = cond & ~cond_d_r[k];
      fall = ~cond & cond_d_r[k] & `RMIS_DBL_MASK;
      // New events win over a clear in the same cycle
      lat_nxt[k] = (lat_r[k] & ~sel) | evt | cond;
      rdc_nxt[k] = (rdc_r[k] & ~sel) | (lat_r[k] & sel);
      ilat_nxt[k] = (ilat_r[k] & ~sel) | evt | rise | fall;
      cond_d_nxt[k] = cond;
      imr_nxt[k] = imr_r[k];
      if (bus.wr && bus.addr == 8'(st_addr(k) + 8'h01))
        imr_nxt[k] = bus.wdata;
    end
    // Information registers: latched, no interrupt path
    for (int k = `RMIS_NSR; k < `RMIS_NST; k++)
    begin
      sel = wsel(bus.wr, bus.addr, st_addr(k), bus.wdata);
      evt = info_event_in[(k - `RMIS_NSR)*8 +: 8] & ~`RMIS_INFO_LIVE;
      lat_nxt[k] = (lat_r[k] & ~sel) | evt;
      rdc_nxt[k] = (rdc_r[k] & ~sel) | (lat_r[k] & sel);
    end
    // Control registers
    if (bus.wr && bus.addr == `RMIS_A_MMR)
    begin
      mmr_nxt = bus.wdata & `RMIS_MMR_WMASK;
      if (bus.wdata[`RMIS_MMR_SRST] && !mmr_r[`RMIS_MMR_SRST])
        srst_cnt_nxt = `RMIS_SRST_CYC;
    end
    if (bus.wr && bus.addr == `RMIS_A_LINE_IF_CONTROL_2)
    begin
      line_if_control_2_nxt = bus.wdata;
      line_if_reset_bit_nxt = bus.wdata[`RMIS_LINE_IF_CONTROL_2_LINE_IF_RESET_BIT] &&
                  !line_if_control_2_r[`RMIS_LINE_IF_CONTROL_2_LINE_IF_RESET_BIT];
    end
    if (bus.wr && bus.addr == `RMIS_A_COMMON_CONTROL_3)
      common_control_3_nxt = bus.wdata;
    if (srst_cnt_r != 4'h0)
      srst_cnt_nxt = srst_cnt_r - 4'h1;
    // Chip reset holds everything clear; soft bit stays up until the
    // last clearing cycle so software can poll for completion
    if (clr)
    begin
      mmr_nxt = 8'h00;
      mmr_nxt[`RMIS_MMR_SRST] = hwr_s2_r && (srst_cnt_r > 4'h1);
      if (!hwr_s2_r)
        srst_cnt_nxt = 4'h0;
      line_if_control_2_nxt = 8'h00;
      common_control_3_nxt = 8'h00;
      line_if_reset_bit_nxt = 1'b0;
      lat_nxt = '{default: 8'h00};
      rdc_nxt = '{default: 8'h00};
      ilat_nxt = '{default: 8'h00};
      imr_nxt = '{default: 8'h00};
      cond_d_nxt = '{default: 8'h00};
    end
    // Read path stays alive during reset for polling
    rvalid_nxt = bus.rd;
    rdata_nxt = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        `RMIS_A_MMR: rdata_nxt = mmr_r;
        `RMIS_A_INTERRUPT_SOURCE_SUMMARY_LOW: rdata_nxt = interrupt_source_summary_low;
        `RMIS_A_INTERRUPT_SOURCE_SUMMARY_HIGH: rdata_nxt = interrupt_source_summary_high;
        `RMIS_A_LINE_IF_CONTROL_2: rdata_nxt = line_if_control_2_r;
        `RMIS_A_COMMON_CONTROL_3: rdata_nxt = common_control_3_r;
        `RMIS_A_SYNC_REALTIME_INFO: rdata_nxt = sync_realtime_in;
        default: rdata_nxt = 8'h00;
      endcase
      for (int k = 0; k < `RMIS_NSR; k++)
      begin
        if (bus.addr == st_addr(k))
          rdata_nxt = rdc_r[k];
        if (bus.addr == 8'(st_addr(k) + 8'h01))
          rdata_nxt = imr_r[k];
      end
      for (int k = `RMIS_NSR; k < `RMIS_NST; k++)
        if (bus.addr == st_addr(k))
          rdata_nxt = (rdc_r[k] & ~`RMIS_INFO_LIVE) |
            (info_live_in[(k - `RMIS_NSR)*8 +: 8] &
             `RMIS_INFO_LIVE);
    end
  end

  // Register stage; power-up reset clears the whole space
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      mmr_r <= 8'h00;
      line_if_control_2_r <= 8'h00;
      common_control_3_r <= 8'h00;
      srst_cnt_r <= 4'h0;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      line_if_reset_bit_r <= 1'b0;
      lat_r <= '{default: 8'h00};
      rdc_r <= '{default: 8'h00};
      ilat_r <= '{default: 8'h00};
      imr_r <= '{default: 8'h00};
      cond_d_r <= '{default: 8'h00};
    end
    else
    begin
      mmr_r <= mmr_nxt;
      line_if_control_2_r <= line_if_control_2_nxt;
      common_control_3_r <= common_control_3_nxt;
      srst_cnt_r <= srst_cnt_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      line_if_reset_bit_r <= line_if_reset_bit_nxt;
      lat_r <= lat_nxt;
      rdc_r <= rdc_nxt;
      ilat_r <= ilat_nxt;
      imr_r <= imr_nxt;
      cond_d_r <= cond_d_nxt;
    end
  end

  // Test modes override the pins; tri-state also frees the data bus.
  // In normal mode the pin is open drain, so only the enable carries
  // the request; the forced levels drive it whatever is pending.
  assign tri_mode = mmr_r[`RMIS_MMR_TLO] && !mmr_r[`RMIS_MMR_THI];
  assign bus.irq_o = mmr_r[`RMIS_MMR_THI] && mmr_r[`RMIS_MMR_TLO];
  assign bus.irq_oe = mmr_r[`RMIS_MMR_THI] ||
                      (!mmr_r[`RMIS_MMR_TLO] && irq_act);

  // Outputs
  assign bus.rdata = rdata_r;
  assign bus.data_oe = rvalid_r && !tri_mode;
  assign mode_e1_out = mmr_r[`RMIS_MMR_E1];
  assign force_tristate_out = tri_mode;
  assign force_low_out = mmr_r[`RMIS_MMR_THI] && !mmr_r[`RMIS_MMR_TLO];
  assign force_high_out = mmr_r[`RMIS_MMR_THI] && mmr_r[`RMIS_MMR_TLO];
  assign line_if_reset_out = line_if_reset_bit_r;
  assign chip_reset_out = clr;
  assign extended_status_bus_irq_out = |interrupt_source_summary_low || |interrupt_source_summary_high;
  assign extended_status_bus_sync_out = !cond_d_r[`RMIS_LOS_REG][`RMIS_LOS_BIT];

endmodule // rmis_device

// ===== rmis_host.sv
// Host end: sequences port cycles for the user, including the status
// write-then-read pair, the line reset wait and the handler bracket.
// Assumes the device end shares mclk_in and answers reads next cycle.
`timescale 1ns/1ps
`include "rmis_defs.svh"
module rmis_host #(
  parameter int unsigned LI_WAIT_CYC = `RMIS_LI_WAIT_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  rmis_if.host bus,
  input wire logic cmd_valid_in,
  input wire rmis_pkg::rmis_op_t cmd_op_in,
  input wire logic [7:0] cmd_addr_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic irq_active_out
);

  rmis_pkg::rmis_hstate_t st_r, st_nxt;
  rmis_pkg::rmis_op_t op_r, op_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wr_r, wr_nxt;
  logic rd_r, rd_nxt;
  logic hwn_r, hwn_nxt;
  logic [20:0] cnt_r, cnt_nxt;
  logic [7:0] rsp_r, rsp_nxt;
  logic irq_s1_r;
  logic irq_s2_r;

  // Interrupt pin is asynchronous to us: two flops first
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      irq_s1_r <= 1'b1;
      irq_s2_r <= 1'b1;
    end
    else
    begin
      irq_s1_r <= bus.irq_n;
      irq_s2_r <= irq_s1_r;
    end
  end

  // Sequencer next state
  always_comb
  begin
    st_nxt = st_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    hwn_nxt = hwn_r;
    cnt_nxt = cnt_r;
    rsp_nxt = rsp_r;
    unique case (st_r)
      rmis_pkg::HS_IDLE:
        if (cmd_valid_in)
        begin
          op_nxt = cmd_op_in;
          addr_nxt = cmd_addr_in;
          wdata_nxt = cmd_data_in;
          wr_nxt = 1'b1;
          st_nxt = rmis_pkg::HS_WSTB;
          unique case (cmd_op_in)
            rmis_pkg::OP_WR:
              if (cmd_addr_in == `RMIS_A_MMR)
                wdata_nxt = cmd_data_in & `RMIS_MMR_WMASK;
            rmis_pkg::OP_SRD:
              st_nxt = rmis_pkg::HS_WSTB;
            rmis_pkg::OP_RD:
            begin
              wr_nxt = 1'b0;
              rd_nxt = 1'b1;
              st_nxt = rmis_pkg::HS_RSTB;
            end
            rmis_pkg::OP_LINE_IF_RESET_BIT:
            begin
              addr_nxt = `RMIS_A_LINE_IF_CONTROL_2;
              wdata_nxt = cmd_data_in & ~`RMIS_LINE_IF_RESET_BIT_MASK;
            end
            rmis_pkg::OP_IRQ_ENTER:
            begin
              addr_nxt = `RMIS_A_COMMON_CONTROL_3;
              wdata_nxt = cmd_data_in | `RMIS_IRQ_PIN_DISABLE_MASK;
            end
            rmis_pkg::OP_IRQ_EXIT:
            begin
              addr_nxt = `RMIS_A_COMMON_CONTROL_3;
              wdata_nxt = cmd_data_in & ~`RMIS_IRQ_PIN_DISABLE_MASK;
            end
            rmis_pkg::OP_HWRST:
            begin
              wr_nxt = 1'b0;
              hwn_nxt = 1'b0;
              cnt_nxt = `RMIS_HWRST_CYC;
              st_nxt = rmis_pkg::HS_HWRST;
            end
            default:
            begin
              wr_nxt = 1'b0;
              st_nxt = rmis_pkg::HS_RESP;
            end
          endcase
        end
      rmis_pkg::HS_WSTB:
        if (op_r == rmis_pkg::OP_SRD)
        begin
          rd_nxt = 1'b1;
          st_nxt = rmis_pkg::HS_RSTB;
        end
        else if (op_r == rmis_pkg::OP_LINE_IF_RESET_BIT &&
                 !wdata_r[`RMIS_LINE_IF_CONTROL_2_LINE_IF_RESET_BIT])
        begin
          wdata_nxt = wdata_r | `RMIS_LINE_IF_RESET_BIT_MASK;
          wr_nxt = 1'b1;
        end
        else if (op_r == rmis_pkg::OP_LINE_IF_RESET_BIT)
        begin
          cnt_nxt = 21'(LI_WAIT_CYC);
          st_nxt = rmis_pkg::HS_LIWAIT;
        end
        else
          st_nxt = rmis_pkg::HS_RESP;
      rmis_pkg::HS_RSTB:
        st_nxt = rmis_pkg::HS_RWAIT;
      rmis_pkg::HS_RWAIT:
      begin
        rsp_nxt = bus.data_bus;
        st_nxt = rmis_pkg::HS_RESP;
      end
      // No elastic stores behind this port, so no store reset follows
      rmis_pkg::HS_LIWAIT, rmis_pkg::HS_HWRST:
        if (cnt_r <= 21'h000001)
        begin
          hwn_nxt = 1'b1;
          st_nxt = rmis_pkg::HS_RESP;
        end
        else
          cnt_nxt = cnt_r - 21'h000001;
      rmis_pkg::HS_RESP:
        st_nxt = rmis_pkg::HS_IDLE;
    endcase
  end

  // Register stage
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= rmis_pkg::HS_IDLE;
      op_r <= rmis_pkg::OP_WR;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      hwn_r <= 1'b1;
      cnt_r <= 21'h000000;
      rsp_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      hwn_r <= hwn_nxt;
      cnt_r <= cnt_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr = wr_r;
  assign bus.rd = rd_r;
  assign bus.hw_chip_reset_pin_n = hwn_r;
  assign cmd_ready_out = (st_r == rmis_pkg::HS_IDLE);
  assign rsp_valid_out = (st_r == rmis_pkg::HS_RESP);
  assign rsp_data_out = rsp_r;
  assign irq_active_out = !irq_s2_r;

endmodule // rmis_host

// ===== rmis_if.sv
// Parallel control port between the host and the device end.
// Assumes both ends run on the same clock; pins resolve here.
`timescale 1ns/1ps
interface rmis_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic hw_chip_reset_pin_n;
  logic [7:0] rdata;
  logic data_oe;
  logic irq_o;
  logic irq_oe;
  logic irq_n;
  logic [7:0] data_bus;

  // Pull-ups on the shared pins
  assign irq_n = irq_oe ? irq_o : 1'b1;
  assign data_bus = data_oe ? rdata : 8'hff;

  modport dev (
    input addr, wdata, wr, rd, hw_chip_reset_pin_n,
    output rdata, data_oe, irq_o, irq_oe
  );
  modport host (
    output addr, wdata, wr, rd, hw_chip_reset_pin_n,
    input data_bus, irq_n
  );
endinterface

// ===== rmis_pkg.sv
// Types shared by both ends of the reset/mode/status block.
// Assumes nothing of its surroundings.
package rmis_pkg;

  // Host sequencer states, one-hot
  typedef enum logic [6:0] {
    HS_IDLE = 7'h01,
    HS_WSTB = 7'h02,
    HS_RSTB = 7'h04,
    HS_RWAIT = 7'h08,
    HS_LIWAIT = 7'h10,
    HS_HWRST = 7'h20,
    HS_RESP = 7'h40
  } rmis_hstate_t;

  // Host user commands
  typedef enum logic [2:0] {
    OP_WR = 3'h0,
    OP_RD = 3'h1,
    OP_SRD = 3'h2,
    OP_LINE_IF_RESET_BIT = 3'h3,
    OP_IRQ_ENTER = 3'h4,
    OP_IRQ_EXIT = 3'h5,
    OP_HWRST = 3'h6
  } rmis_op_t;

endpackage

// ===== rmis_props.sv
// Checker on the parallel port joining the host and device ends.
// Assumes instantiation beside the interface in the bench top.
`timescale 1ns/1ps
module rmis_props (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic hw_chip_reset_pin_n,
  input wire logic [7:0] rdata,
  input wire logic data_oe,
  input wire logic irq_o,
  input wire logic irq_oe
);
  logic [3:0] age_r;
  logic [3:0] age_nxt;
  logic [2:0] mmr_r;
  logic [2:0] mmr_nxt;
  logic [1:0] mode;

  // Shadow of mode bits and age of the last soft reset request
  always_comb
  begin
    mmr_nxt = mmr_r;
    age_nxt = (age_r == 4'hf) ? age_r : age_r + 4'h1;
    if (wr && addr == 8'h00)
      mmr_nxt = wdata[0] ? 3'h0 : wdata[3:1];
    if (wr && addr == 8'h00 && wdata[0])
      age_nxt = 4'h0;
    if (!hw_chip_reset_pin_n)
      mmr_nxt = 3'h0;
  end

  // Starts aged out, so a fresh run never looks mid soft reset
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      mmr_r <= 3'h0;
      age_r <= 4'hf;
    end
    else
    begin
      mmr_r <= mmr_nxt;
      age_r <= age_nxt;
    end
  end

  assign mode = mmr_r[2:1];

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_upper_mode_zero: assert property (
    rd && addr == 8'h00 |=> !data_oe || rdata[7:4] == 4'h0)
    else $error("mode register upper bits not zero");
  a_soft_reset_done: assert property (
    rd && addr == 8'h00 && age_r >= 4'h5 |=> !data_oe || !rdata[0])
    else $error("soft reset bit still set");
  a_mode_readback: assert property (
    rd && addr == 8'h00 && age_r >= 4'h5 && mode != 2'h1
    |=> rdata[3:1] == $past(mmr_r))
    else $error("mode bits read back wrong");
  a_tristate_port: assert property (
    mode == 2'h1 && rd |=> !data_oe)
    else $error("data driven in tri-state mode");
  a_force_low: assert property (
    mode == 2'h2 && $past(mode) == 2'h2 |-> irq_oe && !irq_o)
    else $error("interrupt pin not forced low");
  a_force_high: assert property (
    mode == 2'h3 && $past(mode) == 2'h3 |-> irq_oe && irq_o)
    else $error("interrupt pin not forced high");
  a_disable_quiets_pin: assert property (
    wr && addr == 8'h31 && wdata[6] && mode == 2'h0
    |-> ##3 !irq_oe [*3])
    else $error("interrupt pin active while disabled");
  a_reset_quiet: assert property (
    $rose(rst_n_in) |-> !irq_oe [*2])
    else $error("interrupt pin active after reset");
  a_summary_hi_clean: assert property (
    rd && addr == 8'h15 |=> !data_oe || rdata[7:2] == 6'h00)
    else $error("unused summary bits set");

  c_soft_reset: cover property (wr && addr == 8'h00 && wdata[0]);
  c_tristate_read: cover property (mode == 2'h1 && rd);
  c_irq_release: cover property ($fell(irq_oe));
endmodule // rmis_props
